// *** logic/ctd_checker.sv ***
// Continuity tone checker: per-channel level and zero-crossing results, loopback
`timescale 1ns/1ns
`include "ctd_regs.svh"
module ctd_checker
  import ctd_pkg::*;
#(
  parameter int INTERVAL_CYCLES = `CTD_INTERVAL_NS / `CTD_CLK_PERIOD_NS,
  parameter logic [`CTD_SAMPLE_W-2:0] LEVEL_BOUND [`CTD_LEVEL_STEPS] =
    '{7'h08, 7'h0C, 7'h12, 7'h1A, 7'h26, 7'h38, 7'h50}
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     arst_n,
  // Incoming channel bus, from the time switch side
  input  wire logic [`CTD_SAMPLE_W-1:0] in_data,
  input  wire logic [`CTD_CHAN_W-1:0]   in_chan,
  input  wire logic [`CTD_PORT_W-1:0]   in_port,
  input  wire logic                     in_strobe,
  // Loopback enables from the message interface
  input  wire logic                     loop_enable,
  input  wire logic [`CTD_CHAN_W-1:0]   loop_chan,
  // Outgoing channel bus, towards the time switch
  output logic      [`CTD_SAMPLE_W-1:0] out_data,
  output logic      [`CTD_CHAN_W-1:0]   out_chan,
  output logic                          out_drive,
  // Result read port for the signaling processor
  input  wire logic [`CTD_CHAN_W-1:0]   rd_chan,
  output logic      [`CTD_LEVEL_W-1:0]  rd_level,
  output logic      [`CTD_COUNT_W-1:0]  rd_count,
  // Result update stream, one word per channel per interval
  output logic                          res_valid,
  input  wire logic                     res_ready,
  output logic      [`CTD_CHAN_W+`CTD_LEVEL_W+`CTD_COUNT_W-1:0] res_word,
  output logic                          res_overrun,
  output logic                          interval_tick
);
  localparam int CW = $clog2(INTERVAL_CYCLES + 1);
  initial begin
    if (INTERVAL_CYCLES < `CTD_NUM_CHAN * 4) $error("ctd_checker: interval too short for a channel sweep");
  end

  // Grade a magnitude against the bound table
  function automatic ctd_level_t grade(input logic [`CTD_SAMPLE_W-2:0] mag);
    ctd_level_t g;
    g = '0;
    for (int i = 0; i < `CTD_LEVEL_STEPS; i++) begin
      if (mag >= LEVEL_BOUND[i]) g = ctd_level_t'(i + 1);
    end
    return g;
  endfunction

  // Sign-magnitude samples: magnitude without the sign bit
  function automatic logic [`CTD_SAMPLE_W-2:0] mag_of(input ctd_sample_t s);
    return s[`CTD_SAMPLE_W-2:0];
  endfunction

  // Input synchronisers; the bus arrives from another card
  ctd_sample_t  d1_reg, d2_reg;
  ctd_chan_t    c1_reg, c2_reg, lc1_reg, lc2_reg;
  logic [`CTD_PORT_W-1:0] p1_reg, p2_reg;
  logic         s1_reg, s2_reg, s3_reg, le1_reg, le2_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {d1_reg, d2_reg, c1_reg, c2_reg, p1_reg, p2_reg} <= '0;
      {s1_reg, s2_reg, s3_reg, le1_reg, le2_reg, lc1_reg, lc2_reg} <= '0;
    end else begin
      {d1_reg, c1_reg, p1_reg, s1_reg} <= {in_data, in_chan, in_port, in_strobe};
      {d2_reg, c2_reg, p2_reg, s2_reg} <= {d1_reg, c1_reg, p1_reg, s1_reg};
      s3_reg <= s2_reg;
      {le1_reg, lc1_reg} <= {loop_enable, loop_chan};
      {le2_reg, lc2_reg} <= {le1_reg, lc1_reg};
    end
  end

  // A sample is taken on the rising strobe when the bus carries our port
  wire       take     = s2_reg && !s3_reg && (p2_reg == `CTD_PORT_W'(`CTD_PORT_ID));
  ctd_chan_t ch;
  assign ch = c2_reg;

  // Per-channel working state and result buffer, indexed by channel
  ctd_sample_t prev_reg  [`CTD_NUM_CHAN];
  logic        seen_reg  [`CTD_NUM_CHAN];
  ctd_count_t  acc_reg   [`CTD_NUM_CHAN];
  logic [`CTD_SAMPLE_W-2:0] peak_reg [`CTD_NUM_CHAN];
  ctd_level_t  lvl_reg   [`CTD_NUM_CHAN];
  ctd_count_t  cnt_reg   [`CTD_NUM_CHAN];
  logic        due_reg   [`CTD_NUM_CHAN];

  // Zero crossing: sign flips against the previous sample, ignoring true zeros
  wire zc_pulse = take && seen_reg[ch] && (d2_reg[`CTD_SIGN_BIT] != prev_reg[ch][`CTD_SIGN_BIT])
                  && (mag_of(d2_reg) != `CTD_ZERO_MAG);
  wire [`CTD_SAMPLE_W-2:0] cur_mag = mag_of(d2_reg);
  wire [`CTD_SAMPLE_W-2:0] new_peak = (cur_mag > peak_reg[ch]) ? cur_mag : peak_reg[ch];
  wire acc_sat = (acc_reg[ch] == {`CTD_COUNT_W{1'b1}});

  // Interval timer
  logic [CW-1:0] tmr_reg;
  wire tick = (tmr_reg == CW'(INTERVAL_CYCLES - 1));
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) tmr_reg <= '0;
    else         tmr_reg <= tick ? '0 : tmr_reg + 1'b1;
  end

  // Publish whenever a due channel is taken; a full FIFO drops the word and marks an overrun but the buffer still updates
  wire publish = take && due_reg[ch];
  wire fifo_in_ready;

  // Per-channel update in that channel's own slot; the tick marks every channel due
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `CTD_NUM_CHAN; i++) begin
        prev_reg[i] <= '0;
        seen_reg[i] <= 1'b0;
        acc_reg[i]  <= '0;
        peak_reg[i] <= '0;
        lvl_reg[i]  <= '0;
        cnt_reg[i]  <= '0;
        due_reg[i]  <= 1'b0;
      end
    end else begin
      if (tick) begin
        for (int i = 0; i < `CTD_NUM_CHAN; i++) due_reg[i] <= 1'b1;
      end
      if (take) begin
        prev_reg[ch] <= d2_reg;
        seen_reg[ch] <= 1'b1;
        if (publish) begin
          lvl_reg[ch]  <= grade(new_peak);
          cnt_reg[ch]  <= acc_reg[ch] + (zc_pulse && !acc_sat);
          acc_reg[ch]  <= '0;
          peak_reg[ch] <= '0;
          due_reg[ch]  <= tick; // a tick in this very cycle wins
        end else begin
          if (zc_pulse && !acc_sat) acc_reg[ch] <= acc_reg[ch] + 1'b1;
          peak_reg[ch] <= new_peak;
        end
      end
    end
  end

  // Result word into the update FIFO
  wire [`CTD_CHAN_W+`CTD_LEVEL_W+`CTD_COUNT_W-1:0] pub_word =
    {ch, grade(new_peak), ctd_count_t'(acc_reg[ch] + (zc_pulse && !acc_sat))};
  wire fifo_out_valid;
  wire [`CTD_CHAN_W+`CTD_LEVEL_W+`CTD_COUNT_W-1:0] fifo_out_data;
  logic hold_reg;
  wire  fifo_pop = fifo_out_valid && (!hold_reg || (res_valid && res_ready));

  ctd_fifo #(.WIDTH(`CTD_CHAN_W+`CTD_LEVEL_W+`CTD_COUNT_W), .DEPTH(`CTD_FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .in_valid  (publish),
    .in_ready  (fifo_in_ready),
    .in_data   (pub_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Registered stream output stage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_reg    <= 1'b0;
      res_valid   <= 1'b0;
      res_word    <= '0;
      res_overrun <= 1'b0;
    end else begin
      if (fifo_pop) begin
        res_valid <= 1'b1;
        res_word  <= fifo_out_data;
        hold_reg  <= 1'b1;
      end else if (res_valid && res_ready) begin
        res_valid <= 1'b0;
        hold_reg  <= 1'b0;
      end
      res_overrun <= publish && !fifo_in_ready;
    end
  end

  // Read port, registered so the level and count stay consistent
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_level      <= '0;
      rd_count      <= '0;
      interval_tick <= 1'b0;
    end else begin
      rd_level      <= lvl_reg[rd_chan];
      rd_count      <= cnt_reg[rd_chan];
      interval_tick <= tick;
    end
  end

  // Loopback: only the enabled channel is driven back, in its own slot
  wire loop_hit = take && le2_reg && (ch == lc2_reg);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_data  <= '0;
      out_chan  <= '0;
      out_drive <= 1'b0;
    end else begin
      out_drive <= loop_hit;
      if (loop_hit) begin
        out_data <= d2_reg;
        out_chan <= ch;
      end
    end
  end
endmodule

// *** logic/ctd_fifo.sv ***
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/1ns
`include "ctd_regs.svh"
module ctd_fifo
  import ctd_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = `CTD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("ctd_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push;
  wire              pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written without reset; the pointers guard what is read
  always_ff @(posedge ref_clk) begin
    if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

// *** logic/ctd_pkg.sv ***
// Types for the continuity tone checker
`include "ctd_regs.svh"
package ctd_pkg;
  typedef logic [`CTD_CHAN_W-1:0]   ctd_chan_t;
  typedef logic [`CTD_SAMPLE_W-1:0] ctd_sample_t;
  typedef logic [`CTD_LEVEL_W-1:0]  ctd_level_t;
  typedef logic [`CTD_COUNT_W-1:0]  ctd_count_t;
  typedef enum logic [1:0] {CTD_ST_IDLE, CTD_ST_MEASURE, CTD_ST_PUBLISH} ctd_state_t;
endpackage

// *** logic/ctd_regs.svh ***
// Constants for the continuity tone checker
`ifndef CTD_REGS_SVH
`define CTD_REGS_SVH
`define CTD_NUM_CHAN      32
`define CTD_CHAN_W        5
`define CTD_SAMPLE_W      8
`define CTD_PORT_ID       16
`define CTD_PORT_W        5
`define CTD_LEVEL_W       3
`define CTD_COUNT_W       8
`define CTD_FIFO_DEPTH    8
`define CTD_INTERVAL_NS   10000000
`define CTD_CLK_PERIOD_NS 8
`define CTD_SIGN_BIT      7
`define CTD_LEVEL_STEPS   7
`define CTD_ZERO_MAG      7'h00
`endif

// *** test/ctd_checker_assertions.sv ***
// Port-level checks for the tone checker
`timescale 1ns/1ns
`include "ctd_regs.svh"
module ctd_check_sva #(
  parameter int INTERVAL_CYCLES = 200
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // Incoming bus and loop enables
  input wire logic [7:0]  in_data,
  input wire logic [4:0]  in_chan,
  input wire logic [4:0]  in_port,
  input wire logic        loop_enable,
  input wire logic [4:0]  loop_chan,
  // Outputs watched
  input wire logic [7:0]  out_data,
  input wire logic [4:0]  out_chan,
  input wire logic        out_drive,
  input wire logic        res_valid,
  input wire logic        res_ready,
  input wire logic [15:0] res_word,
  input wire logic        res_overrun,
  input wire logic        interval_tick
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  int unsigned gap_reg;
  logic        seen_reg;
  // Cycles since the last tick; the first tick after reset has no reference
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg  <= 0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg  <= interval_tick ? 0 : gap_reg + 1;
      seen_reg <= seen_reg | interval_tick;
    end
  end
  reset_quiet_a: assert property ($rose(arst_n) |-> !out_drive && !res_valid && !res_overrun && !interval_tick)
    else $error("output active at reset release");
  drive_data_a: assert property (out_drive |-> out_data == in_data && out_chan == in_chan && in_port == `CTD_PORT_ID)
    else $error("looped sample differs from bus");
  drive_loop_a: assert property (out_drive |-> loop_enable && out_chan == loop_chan)
    else $error("loop of a channel not enabled");
  drive_pulse_a: assert property (out_drive |=> !out_drive)
    else $error("loop drive longer than one cycle");
  tick_early_a: assert property (interval_tick && seen_reg |-> gap_reg == INTERVAL_CYCLES - 1)
    else $error("interval tick early");
  tick_late_a: assert property (seen_reg |-> gap_reg < INTERVAL_CYCLES)
    else $error("interval tick late");
  tick_pulse_a: assert property (interval_tick |=> !interval_tick)
    else $error("tick longer than one cycle");
  res_hold_a: assert property (res_valid && !res_ready |=> res_valid && $stable(res_word))
    else $error("result word dropped while stalled");
  overrun_flag_a: assert property (res_overrun |-> res_valid ##1 !res_overrun)
    else $error("overrun without full buffer");
  loop_seen_c: cover property (out_drive);
  word_taken_c: cover property (res_valid && res_ready);
  overrun_seen_c: cover property (res_overrun);
endmodule
bind ctd_checker ctd_check_sva #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) checks (.ref_clk, .arst_n, .in_data, .in_chan,
  .in_port, .loop_enable, .loop_chan, .out_data, .out_chan, .out_drive, .res_valid, .res_ready, .res_word,
  .res_overrun, .interval_tick);

// *** test/ctd_far_side.sv ***
// Far side model: time switch bus, loop enables, result reader
`timescale 1ns/1ns
module ctd_far_side (
  // Clock
  input wire logic         ref_clk,
  // Incoming bus
  output logic [7:0]       in_data,
  output logic [4:0]       in_chan,
  output logic [4:0]       in_port,
  output logic             in_strobe,
  // Loop enables
  output logic             loop_enable,
  output logic [4:0]       loop_chan,
  // Result stream
  input wire logic         res_valid,
  output logic             res_ready,
  input wire logic [15:0]  res_word
);
  logic        stall = 1'b0;
  logic [15:0] words[$];
  initial begin
    in_data = 8'h00;
    in_chan = 5'h00;
    in_port = 5'h00;
    in_strobe = 1'b0;
    loop_enable = 1'b0;
    loop_chan = 5'h00;
  end
  assign res_ready = !stall;
  // Results kept for judgement by the reader
  always @(posedge ref_clk) if (res_valid && res_ready) words.push_back(res_word);
  // One channel of one enable at a time
  task set_loop(input logic en, input logic [4:0] ch);
    @(posedge ref_clk);
    loop_enable <= en;
    loop_chan <= ch;
  endtask
  // Tone sample; the bus shows the inverse once released
  task send(input logic [4:0] ch, input logic [4:0] pt, input logic [7:0] d);
    @(posedge ref_clk);
    in_data <= d;
    in_chan <= ch;
    in_port <= pt;
    repeat (3) @(posedge ref_clk);
    in_strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    in_strobe <= 1'b0;
    in_data <= ~d;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the tone checker
`timescale 1ns/1ns
module testbench;
  localparam int IVL = 400;
  logic ref_clk, arst_n;
  logic [4:0] rd_chan = 5'h00;
  wire logic [7:0] in_data, out_data;
  wire logic [4:0] in_chan, in_port, loop_chan, out_chan;
  wire logic [2:0] rd_level;
  wire logic [7:0] rd_count;
  wire logic [15:0] res_word;
  wire logic in_strobe, loop_enable, out_drive, res_valid, res_ready, res_overrun, interval_tick;
  int bad_count = 0, samples_checked = 0, drv_cnt = 0, ovr_cnt = 0;
  logic [15:0] last_out, v;
  const logic [7:0] mag[10] = '{8'h04, 8'h08, 8'h0C, 8'h12, 8'h1A, 8'h26, 8'h38, 8'h50, 8'h51, 8'h7F};
  ctd_checker #(.INTERVAL_CYCLES(IVL)) DUT (.ref_clk, .arst_n, .in_data, .in_chan, .in_port, .in_strobe,
    .loop_enable, .loop_chan, .out_data, .out_chan, .out_drive, .rd_chan, .rd_level, .rd_count, .res_valid,
    .res_ready, .res_word, .res_overrun, .interval_tick);
  ctd_far_side far (.ref_clk, .in_data, .in_chan, .in_port, .in_strobe, .loop_enable, .loop_chan, .res_valid,
    .res_ready, .res_word);
  // Pulses counted in the cycle they stand
  always @(posedge ref_clk) begin
    if (out_drive === 1'b1) drv_cnt++;
    if (out_drive === 1'b1) last_out = {3'h0, out_chan, out_data};
    if (res_overrun === 1'b1) ovr_cnt++;
  end
  task check(input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task read_entry(input logic [4:0] ch);
    @(posedge ref_clk);
    rd_chan <= ch;
    repeat (2) @(posedge ref_clk);
    #1 v = {5'h00, rd_level, rd_count};
  endtask
  // Bounded wait, a missing tick counts against the run
  task wait_tick;
    int n;
    // Step off the edge first so the pulse is never read while it is being launched
    #1;
    for (n = 0; n < IVL + 8 && interval_tick !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check(16'h0001, {15'h0000, interval_tick});
    @(posedge ref_clk);
  endtask
  task test_reset;
    #1 check(16'h0000, {12'h000, out_drive, res_valid, res_overrun, interval_tick});
    read_entry(5'h00);
    check(16'h0000, v);
    $display("test reset done");
  endtask
  task test_loop;
    far.set_loop(1'b1, 5'h05);
    far.send(5'h05, 5'h10, 8'h2A);
    far.send(5'h06, 5'h10, 8'h11);
    far.send(5'h05, 5'h03, 8'h33);
    far.set_loop(1'b0, 5'h05);
    far.send(5'h05, 5'h10, 8'h44);
    check(16'h0001, 16'(drv_cnt));
    check(16'h052A, last_out);
    $display("test loop done");
  endtask
  task test_tone;
    wait_tick();
    far.send(5'h03, 5'h10, 8'h30);
    far.send(5'h03, 5'h10, 8'hB0);
    far.send(5'h03, 5'h0F, 8'h30);
    far.send(5'h03, 5'h10, 8'hB0);
    far.send(5'h03, 5'h10, 8'h30);
    wait_tick();
    far.send(5'h03, 5'h10, 8'hB0);
    repeat (8) @(posedge ref_clk);
    check({5'h03, 3'h5, 8'h03}, far.words[$]);
    read_entry(5'h03);
    check(16'h0503, v);
    read_entry(5'h04);
    check(16'h0000, v);
    $display("test tone done");
  endtask
  task test_fill;
    far.words.delete();
    @(posedge ref_clk);
    far.stall <= 1'b1;
    wait_tick();
    // One word waits in the output stage and eight fill the FIFO, so only the tenth is lost
    for (int i = 0; i < 10; i++) far.send(5'(10 + i), 5'h10, mag[i]);
    check(16'h0001, 16'(ovr_cnt));
    @(posedge ref_clk);
    far.stall <= 1'b0;
    repeat (24) @(posedge ref_clk);
    check(16'h0009, 16'(far.words.size()));
    for (int i = 0; i < 9; i++) check({5'(10 + i), 3'(i < 8 ? i : 7), 8'h00}, far.words[i]);
    read_entry(5'h12);
    check(16'h0700, v);
    // The lost word's channel must still be updated in the buffer
    read_entry(5'h13);
    check(16'h0700, v);
    $display("test fill done");
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Clock at 125 MHz
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Main sequence
  initial begin
    arst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    test_reset();
    test_loop();
    test_tone();
    test_fill();
    wrap_up();
  end
  // Watchdog, well past four intervals of traffic
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule
